// [rtl/bcw_pkg.sv]
// Package for the bit-clear and watchdog-clear execution block
package bcw_pkg;
   localparam int unsigned DATA_W    = 8;
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned BIT_SEL_W = 3;

   // Operation codes issued by the decode path
   typedef enum logic [2:0] {
      BCW_OP_NONE   = 3'h0,
      BCW_OP_CLRBIT = 3'h1,
      BCW_OP_WDCLR  = 3'h2,
      BCW_OP_PRE1   = 3'h3,
      BCW_OP_PRE2   = 3'h4
   } bcw_op_t;

   // Which pre-clear ran last (one-hot)
   typedef enum logic [2:0] {
      BCW_PRE_NONE = 3'h1,
      BCW_PRE_ONE  = 3'h2,
      BCW_PRE_TWO  = 3'h4
   } bcw_pre_t;

   typedef struct packed {
      logic                 valid;
      bcw_op_t              op;
      logic [ADDR_W-1:0]    addr;
      logic [BIT_SEL_W-1:0] bit_sel;
      logic [DATA_W-1:0]    rd_data;
   } bcw_instr_t;

   typedef struct packed {
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } bcw_mem_wr_t;

   localparam logic [DATA_W-1:0] BIT_ONE   = 8'h01;
   localparam logic              FLAG_CLR  = 1'h0;
   localparam logic              FLAG_SET  = 1'h1;
endpackage

// [rtl/bcw_exec.sv]
// Execution logic for clear-bit and watchdog-clear instructions
`timescale 1ns/100ps

module bcw_exec (
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   input  wire bcw_pkg::bcw_instr_t instr,
   input  wire logic               timeout_set,
   input  wire logic               powerdown_set,
   output logic                    mem_wr_valid,
   output bcw_pkg::bcw_mem_wr_t    mem_wr,
   output logic                    watchdog_counter_clr,
   output logic                    timeout_flag,
   output logic                    powerdown_flag
);

   // ==========================================================
   // Instruction decode
   // Codes outside the set raise no strobe, so they fall through as no-ops
   logic                       op_clrbit;
   logic                       op_wdclr;
   logic                       op_pre1;
   logic                       op_pre2;

   always_comb begin
      op_clrbit = 1'h0;
      op_wdclr  = 1'h0;
      op_pre1   = 1'h0;
      op_pre2   = 1'h0;
      if (instr.valid) begin
         unique case (instr.op)
            bcw_pkg::BCW_OP_CLRBIT: begin
               op_clrbit = 1'h1;
            end
            bcw_pkg::BCW_OP_WDCLR: begin
               op_wdclr = 1'h1;
            end
            bcw_pkg::BCW_OP_PRE1: begin
               op_pre1 = 1'h1;
            end
            bcw_pkg::BCW_OP_PRE2: begin
               op_pre2 = 1'h1;
            end
            default: begin
               op_clrbit = 1'h0;
            end
         endcase
      end
   end

   // ==========================================================
   // Pre-clear record
   // Starts at none, so the first pre-clear after reset never acts
   bcw_pkg::bcw_pre_t          pre_reg;
   bcw_pkg::bcw_pre_t          pre_next;
   logic                       pre_alt;
   logic                       last_one;
   logic                       last_two;

   // An illegal record code reads as none, so an upset can only cost one clear
   always_comb begin
      last_one = 1'h0;
      last_two = 1'h0;
      unique case (pre_reg)
         bcw_pkg::BCW_PRE_NONE: begin
            last_one = 1'h0;
         end
         bcw_pkg::BCW_PRE_ONE: begin
            last_one = 1'h1;
         end
         bcw_pkg::BCW_PRE_TWO: begin
            last_two = 1'h1;
         end
         default: begin
            last_one = 1'h0;
         end
      endcase
   end

   always_comb begin
      pre_next = pre_reg;
      pre_alt  = 1'h0;
      if (op_pre1) begin
         pre_alt  = last_two;
         pre_next = bcw_pkg::BCW_PRE_ONE;
      end
      if (op_pre2) begin
         pre_alt  = last_one;
         pre_next = bcw_pkg::BCW_PRE_TWO;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_reg <= bcw_pkg::BCW_PRE_NONE;
      end else begin
         pre_reg <= pre_next;
      end
   end

   // ==========================================================
   // Watchdog counter clear
   // The single-step clear bypasses the record, so a pending pair is not disturbed
   logic                       wd_clear;
   logic                       wdc_reg;
   logic                       wdc_next;

   always_comb begin
      wd_clear = op_wdclr | pre_alt;
      wdc_next = wd_clear;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdc_reg <= bcw_pkg::FLAG_CLR;
      end else begin
         wdc_reg <= wdc_next;
      end
   end

   // ==========================================================
   // Bit mask for the clear-bit write-back
   logic [bcw_pkg::DATA_W-1:0] keep_mask;

   for (genvar gi = 0; gi < bcw_pkg::DATA_W; gi++) begin : g_keep
      assign keep_mask[gi] = (int'(instr.bit_sel) != gi);
   end

   // ==========================================================
   // Memory write-back
   // Address and data hold while idle, so the write port only toggles on a real write
   bcw_pkg::bcw_mem_wr_t       wr_reg;
   bcw_pkg::bcw_mem_wr_t       wr_next;
   logic                       vld_reg;
   logic                       vld_next;

   always_comb begin
      wr_next    = wr_reg;
      wr_next.we = 1'h0;
      vld_next   = 1'h0;
      if (op_clrbit) begin
         wr_next.we   = 1'h1;
         wr_next.addr = instr.addr;
         wr_next.data = instr.rd_data & keep_mask;
         vld_next     = 1'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg  <= '0;
         vld_reg <= 1'h0;
      end else begin
         wr_reg  <= wr_next;
         vld_reg <= vld_next;
      end
   end

   // ==========================================================
   // Timeout flag
   // A set in the same cycle as a clear wins, so a fresh timeout is never lost
   logic                       to_reg;
   logic                       to_next;

   always_comb begin
      to_next = to_reg;
      if (wd_clear) begin
         to_next = bcw_pkg::FLAG_CLR;
      end
      if (timeout_set) begin
         to_next = bcw_pkg::FLAG_SET;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         to_reg <= bcw_pkg::FLAG_CLR;
      end else begin
         to_reg <= to_next;
      end
   end

   // ==========================================================
   // Powerdown flag
   // Same priority as the timeout flag: a set beats a clear in one cycle
   logic                       pd_reg;
   logic                       pd_next;

   always_comb begin
      pd_next = pd_reg;
      if (wd_clear) begin
         pd_next = bcw_pkg::FLAG_CLR;
      end
      if (powerdown_set) begin
         pd_next = bcw_pkg::FLAG_SET;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pd_reg <= bcw_pkg::FLAG_CLR;
      end else begin
         pd_reg <= pd_next;
      end
   end

   // ==========================================================
   // Outputs, each straight from a flip-flop
   assign mem_wr_valid         = vld_reg;
   assign mem_wr               = wr_reg;
   assign watchdog_counter_clr = wdc_reg;
   assign timeout_flag         = to_reg;
   assign powerdown_flag       = pd_reg;

endmodule // bcw_exec

// [sim/bcw_monitor.sv]
// Checker for the bit-clear and watchdog-clear block
`timescale 1ns/100ps
module bcw_monitor (
   input wire logic                 ref_clk,
   input wire logic                 rst_n,
   input wire bcw_pkg::bcw_instr_t  instr,
   input wire logic                 timeout_set,
   input wire logic                 powerdown_set,
   input wire logic                 mem_wr_valid,
   input wire bcw_pkg::bcw_mem_wr_t mem_wr,
   input wire logic                 watchdog_counter_clr,
   input wire logic                 timeout_flag,
   input wire logic                 powerdown_flag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_op(bcw_pkg::bcw_op_t o);
      instr.valid && instr.op == o;
   endsequence
   // Two issues with one idle cycle between, the decode path's densest pacing
   sequence s_gap(bcw_pkg::bcw_op_t a, bcw_pkg::bcw_op_t b);
      s_op(a) ##1 !instr.valid ##1 s_op(b);
   endsequence
   sequence s_quiet;
      !timeout_set && !powerdown_set;
   endsequence
   sequence s_clr;
      watchdog_counter_clr && !timeout_flag && !powerdown_flag;
   endsequence

   property p_bit;
      s_op(bcw_pkg::BCW_OP_CLRBIT) |=> mem_wr_valid && mem_wr.addr == $past(instr.addr)
         && mem_wr.data == ($past(instr.rd_data) & ~(bcw_pkg::BIT_ONE << $past(instr.bit_sel)));
   endproperty
   a_bit: assert property (p_bit) else $error("bit clear write wrong");
   property p_wd;
      s_op(bcw_pkg::BCW_OP_WDCLR) ##0 s_quiet |=> s_clr;
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog clear missed");
   property p_alt;
      s_gap(bcw_pkg::BCW_OP_PRE2, bcw_pkg::BCW_OP_PRE1) ##0 s_quiet |=> s_clr;
   endproperty
   a_alt: assert property (p_alt) else $error("alternating first clear missed");
   property p_alt2;
      s_gap(bcw_pkg::BCW_OP_PRE1, bcw_pkg::BCW_OP_PRE2) ##0 s_quiet |=> s_clr;
   endproperty
   a_alt2: assert property (p_alt2) else $error("alternating second clear missed");
   property p_rep1;
      s_gap(bcw_pkg::BCW_OP_PRE1, bcw_pkg::BCW_OP_PRE1) |=> !watchdog_counter_clr;
   endproperty
   a_rep1: assert property (p_rep1) else $error("repeated first clear acted");
   property p_rep2;
      s_gap(bcw_pkg::BCW_OP_PRE2, bcw_pkg::BCW_OP_PRE2) |=> !watchdog_counter_clr;
   endproperty
   a_rep2: assert property (p_rep2) else $error("repeated second clear acted");
   property p_cause;
      watchdog_counter_clr |-> $past(instr.valid) && !mem_wr_valid;
   endproperty
   a_cause: assert property (p_cause) else $error("clear without instruction");
endmodule // bcw_monitor
bind bcw_exec bcw_monitor mon_u (.*);

// [sim/bcw_cpu_model.sv]
// Decode path model: issues instructions and holds data memory
`timescale 1ns/100ps
module bcw_cpu_model (
   input  wire logic                 ref_clk,
   input  wire bcw_pkg::bcw_mem_wr_t mem_wr,
   output bcw_pkg::bcw_instr_t       instr
);
   logic [7:0] mem [256];

   initial begin
      instr = '0;
      foreach (mem[i]) mem[i] = 8'hFF ^ 8'(i);
   end

   always @(posedge ref_clk) begin
      if (mem_wr.we) mem[mem_wr.addr] <= mem_wr.data;
   end

   // One-cycle valid pulse; a write landing at this edge is forwarded into the read data
   task automatic issue(bcw_pkg::bcw_op_t o, logic [7:0] a, logic [2:0] b);
      logic [7:0] d;
      @(posedge ref_clk);
      d = (mem_wr.we && mem_wr.addr == a) ? mem_wr.data : mem[a];
      instr <= '{1'h1, o, a, b, d};
      @(posedge ref_clk);
      instr <= '0;
   endtask
endmodule // bcw_cpu_model

// [sim/test_bit_clear_and_watchdog_clear_ops.sv]
// Self-checking testbench for the bit-clear and watchdog-clear block
`timescale 1ns/100ps
module test_bit_clear_and_watchdog_clear_ops;
logic ref_clk = 0, rst_n = 0, ts = 0, ps = 0, mv, wc, tf, pf;
bcw_pkg::bcw_instr_t instr;
bcw_pkg::bcw_mem_wr_t mw;
int error_cnt = 0, comparisons = 0;
logic [31:0] r = 32'hFBD5898F;
logic [7:0] old;
// First pre-clear after reset is ignored; single-step clear keeps the record
logic [2:0] ops [7] = '{3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h2, 3'h3};
logic ex [7] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
// Burst with one idle cycle between issues after a mid-run reset: only alternating pre-clears and the closing single-step clear act
logic [2:0] burst [6] = '{3'h3, 3'h4, 3'h4, 3'h3, 3'h3, 3'h2};
logic bex [6] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
bcw_cpu_model dec_u (.ref_clk(ref_clk), .mem_wr(mw), .instr(instr));
bcw_exec dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .instr(instr), .timeout_set(ts),
   .powerdown_set(ps), .mem_wr_valid(mv), .mem_wr(mw), .watchdog_counter_clr(wc),
   .timeout_flag(tf), .powerdown_flag(pf));
function automatic logic [31:0] lfsr(logic [31:0] x);
   return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
endfunction
function automatic logic [7:0] exp_clr(logic [7:0] v, logic [2:0] b);
   return v & ~(8'h01 << b);
endfunction
task automatic chk(string n, logic [7:0] s, logic [7:0] e);
   comparisons++;
   if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
   end
endtask
task automatic tally_and_finish;
   $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
   if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
   else $display("Finished with errors");
   $finish;
endtask
initial forever #4 ref_clk = ~ref_clk;
initial begin
   #20000 error_cnt++;
   tally_and_finish;
end
initial begin
   repeat (10) @(posedge ref_clk);
   rst_n <= 1;
   for (int i = 0; i < 10; i++) begin
      r = lfsr(r);
      // Corners: top bit of a byte that has it set, bottom bit of another
      if (i == 0) r[10:0] = 11'h700;
      if (i == 1) r[10:0] = 11'h002;
      old = dec_u.mem[r[7:0]];
      dec_u.issue(bcw_pkg::BCW_OP_CLRBIT, r[7:0], r[10:8]);
      #1 chk("mem_wr_valid", mv, 8'h01);
      chk("mem_wr.addr", mw.addr, r[7:0]);
      repeat (2) @(posedge ref_clk);
      #1 chk("mem", dec_u.mem[r[7:0]], exp_clr(old, r[10:8]));
   end
   foreach (ops[i]) begin
      @(posedge ref_clk) {ts, ps} <= 2'h3;
      @(posedge ref_clk) {ts, ps} <= 2'h0;
      dec_u.issue(bcw_pkg::bcw_op_t'(ops[i]), 8'h00, 3'h0);
      #1 chk("flags", {tf, pf}, {2{ex[i]}});
      chk("watchdog_counter_clr", wc, !ex[i]);
   end
   @(posedge ref_clk) {ts, ps} <= 2'h3;
   @(posedge ref_clk) begin
      {ts, ps} <= 2'h0;
      rst_n <= 1'h0;
   end
   #1 chk("flags in reset", {tf, pf}, 8'h00);
   repeat (2) @(posedge ref_clk);
   rst_n <= 1'h1;
   foreach (burst[i]) begin
      dec_u.issue(bcw_pkg::bcw_op_t'(burst[i]), 8'h00, 3'h0);
      #1 chk("burst clear", wc, bex[i]);
   end
   tally_and_finish;
end
endmodule // test_bit_clear_and_watchdog_clear_ops
